// *** hw/gal_regs.vh ***
// register offsets, fields, delay limits and timing counts for the gas alarm latch
`ifndef GAL_REGS_VH
`define GAL_REGS_VH
`define GAL_CTRL_OFF       12'h000
`define GAL_TRIP_OFF       12'h004
`define GAL_CLR_OFF        12'h008
`define GAL_ENTRY_DLY_OFF  12'h00C
`define GAL_EXIT_DLY_OFF   12'h010
`define GAL_CMD_OFF        12'h014
`define GAL_STATUS_OFF     12'h018
`define GAL_TRBL_CODE_OFF  12'h01C
`define GAL_TRBL_WALK_OFF  12'h020
`define GAL_TRBL_ACK_OFF   12'h024
`define GAL_CTRL_DIR_LSB   0
`define GAL_CTRL_MANUAL    2
`define GAL_CTRL_OVR_LSB   3
`define GAL_DIR_NONE       2'h0
`define GAL_DIR_RISE       2'h1
`define GAL_DIR_FALL       2'h2
`define GAL_OVR_HOLD       2'h0
`define GAL_OVR_SET        2'h1
`define GAL_OVR_CLEAR      2'h2
`define GAL_CMD_CLEAR      0
`define GAL_CMD_NEXT       1
`define GAL_ENTRY_MAX_S    4'hA
`define GAL_EXIT_MAX_S     13'h1C20
`define GAL_TICK_PERIOD_NS 1000000000
`define GAL_CLK_PERIOD_NS  10
`define GAL_TICK_CYCLES    (`GAL_TICK_PERIOD_NS / `GAL_CLK_PERIOD_NS)
`endif

// *** hw/gal_latch.v ***
// gas alarm latch: threshold compare, qualify delays, clear modes, trouble override and summary
`default_nettype none
`include "gal_regs.vh"

// Operation
// - auto clear after clear delay elapses
// - manual mode keeps alarm until clear
// - clear from local, serial or remote
// - clear delay used only in auto
// - trouble override beats all other settings except direction none
// - hold keeps state, blocks new activation
// - force set activates at once
// - force clear deactivates at once
// - activate after entry delay continuous trip
// - entry delay zero to ten seconds
// - deactivate after exit delay continuous clear
// - exit delay zero to 7200 seconds
// - default override suppresses and holds
// - self-recovering faults clear by themselves
// - persistent faults held after correction, until reset, or acknowledge if designated
// - 32-bit fault code of all faults
// - next request steps to next fault
// - escape acknowledge clears designated faults
// - direction rising, falling or none
// - trip write also loads clear threshold
// - remote reset clears subsided manual alarms
module gal_latch #(
  parameter         RW          = 16,
  parameter         NF          = 32,
  parameter integer TICK_CYCLES = `GAL_TICK_CYCLES,
  parameter [NF-1:0] SELF_MASK  = 32'h0000_00FF,
  parameter [NF-1:0] ACK_MASK   = 32'h00FF_0000
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // reading and fault sources
  input  wire [RW-1:0] reading,
  input  wire [NF-1:0] fault_raw,
  input  wire          local_clear,
  input  wire          serial_clear,
  input  wire          remote_reset_pin,
  // alarm and trouble outputs
  output reg           alarm_q,
  output reg           trouble_q
);

  reg [1:0]    dir_q;
  reg          manual_q;
  reg [1:0]    ovr_q;
  reg [RW-1:0] trip_q;
  reg [RW-1:0] clr_q;
  reg [3:0]    entry_dly_q;
  reg [12:0]   exit_dly_q;
  reg [NF-1:0] fault_q;
  reg [4:0]    walk_q;
  reg [31:0]   tick_cnt_q;
  reg          tick_q;
  reg [3:0]    entry_cnt_q;
  reg [12:0]   exit_cnt_q;
  reg [1:0]    rr_sync_q;
  reg          rr_prev_q;

  // terminal count of the one-second divider, sized to match the counter
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire cmd_w = wr && paddr == `GAL_CMD_OFF;

  // rising/falling comparisons by direction
  wire on_trip  = dir_q == `GAL_DIR_RISE ? reading >= trip_q :
                  dir_q == `GAL_DIR_FALL ? reading <= trip_q : 1'b0;
  wire on_clear = dir_q == `GAL_DIR_RISE ? reading < clr_q :
                  dir_q == `GAL_DIR_FALL ? reading > clr_q : 1'b0;
  wire trouble  = |fault_q;
  wire rr_rise  = rr_sync_q[1] & ~rr_prev_q;
  wire clr_req  = local_clear | serial_clear | rr_rise | (cmd_w & pwdata[`GAL_CMD_CLEAR]);
  wire entry_done = on_trip & (entry_cnt_q >= entry_dly_q);
  wire exit_done  = on_clear & (exit_cnt_q >= exit_dly_q);

  // next fault index after cur, wrapping; returns cur if none other
  function [4:0] next_fault;
    input [NF-1:0] f;
    input [4:0]    cur;
    integer        i;
    reg            found;
    reg [4:0]      idx;
    begin
      found      = 1'b0;
      next_fault = cur;
      for (i = 1; i <= NF; i = i + 1) begin
        idx = cur + i[4:0];
        if (!found && f[idx]) begin
          found      = 1'b1;
          next_fault = idx;
        end
      end
    end
  endfunction

  // remote reset pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_sync_q <= 2'h0;
      rr_prev_q <= 1'b0;
    end else begin
      rr_sync_q <= {rr_sync_q[0], remote_reset_pin};
      rr_prev_q <= rr_sync_q[1];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // config registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q       <= `GAL_DIR_NONE;
      manual_q    <= 1'b0;
      ovr_q       <= `GAL_OVR_HOLD;
      trip_q      <= {RW{1'b0}};
      clr_q       <= {RW{1'b0}};
      entry_dly_q <= 4'h0;
      exit_dly_q  <= 13'h0;
    end else if (wr) begin
      case (paddr)
        `GAL_CTRL_OFF: begin
          dir_q    <= pwdata[`GAL_CTRL_DIR_LSB +: 2];
          manual_q <= pwdata[`GAL_CTRL_MANUAL];
          ovr_q    <= pwdata[`GAL_CTRL_OVR_LSB +: 2];
        end
        `GAL_TRIP_OFF: begin
          trip_q <= pwdata[RW-1:0];
          clr_q  <= pwdata[RW-1:0];
        end
        `GAL_CLR_OFF: clr_q <= pwdata[RW-1:0];
        // entry delay clamp, whole word so large values never wrap
        `GAL_ENTRY_DLY_OFF: entry_dly_q <= pwdata > {28'h0, `GAL_ENTRY_MAX_S} ?
                                           `GAL_ENTRY_MAX_S : pwdata[3:0];
        // exit delay clamp, whole word so large values never wrap
        `GAL_EXIT_DLY_OFF: exit_dly_q <= pwdata > {19'h0, `GAL_EXIT_MAX_S} ?
                                         `GAL_EXIT_MAX_S : pwdata[12:0];
        default: ;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_cnt_q <= 4'h0;
    end else if (!on_trip) begin
      entry_cnt_q <= 4'h0;
    end else if (tick_q && entry_cnt_q < entry_dly_q) begin
      entry_cnt_q <= entry_cnt_q + 4'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_cnt_q <= 13'h0;
    end else if (!on_clear) begin
      exit_cnt_q <= 13'h0;
    end else if (tick_q && exit_cnt_q < exit_dly_q) begin
      exit_cnt_q <= exit_cnt_q + 13'h1;
    end
  end

  // alarm state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= 1'b0;
    end else if (dir_q == `GAL_DIR_NONE) begin
      alarm_q <= 1'b0;
    end else if (trouble) begin
      case (ovr_q)
        `GAL_OVR_SET:   alarm_q <= 1'b1;
        `GAL_OVR_CLEAR: alarm_q <= 1'b0;
        default:        alarm_q <= alarm_q;
      endcase
    end else if (!alarm_q) begin
      alarm_q <= entry_done;
    end else if (!manual_q) begin
      if (exit_done)
        alarm_q <= 1'b0;
    end else begin
      // manual clear once subsided
      // reading must be on the clearing side of the clear level
      if (clr_req && on_clear)
        alarm_q <= 1'b0;
    end
  end

  // fault summary; set wins over acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q   <= {NF{1'b0}};
      trouble_q <= 1'b0;
    end else begin
      fault_q <= (fault_raw & SELF_MASK) |
                 (fault_raw & ~SELF_MASK) |
                 (fault_q & ~SELF_MASK & ~ACK_MASK) |
                 (fault_q & ACK_MASK &
                  ~({NF{wr && paddr == `GAL_TRBL_ACK_OFF}} & pwdata[NF-1:0]));
      trouble_q <= |fault_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_q <= 5'h0;
    end else if (cmd_w && pwdata[`GAL_CMD_NEXT]) begin
      walk_q <= next_fault(fault_q, walk_q);
    end else if (!fault_q[walk_q] && trouble) begin
      walk_q <= next_fault(fault_q, walk_q);
    end
  end

  // apb answers in the access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `GAL_CTRL_OFF:      prdata <= {27'h0, ovr_q, manual_q, dir_q};
          `GAL_TRIP_OFF:      prdata <= {{(32-RW){1'b0}}, trip_q};
          `GAL_CLR_OFF:       prdata <= {{(32-RW){1'b0}}, clr_q};
          `GAL_ENTRY_DLY_OFF: prdata <= {28'h0, entry_dly_q};
          `GAL_EXIT_DLY_OFF:  prdata <= {19'h0, exit_dly_q};
          `GAL_STATUS_OFF:    prdata <= {28'h0, on_clear, on_trip, trouble, alarm_q};
          `GAL_TRBL_CODE_OFF: prdata <= fault_q;
          `GAL_TRBL_WALK_OFF: prdata <= {26'h0, fault_q[walk_q], walk_q};
          `GAL_CMD_OFF,
          `GAL_TRBL_ACK_OFF:  prdata <= 32'h0;
          default:            pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        case (paddr)
          `GAL_CTRL_OFF, `GAL_TRIP_OFF, `GAL_CLR_OFF, `GAL_ENTRY_DLY_OFF,
          `GAL_EXIT_DLY_OFF, `GAL_CMD_OFF, `GAL_TRBL_ACK_OFF: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/gal_latch_asserts.sv ***
// assertion checker on the gas alarm latch ports
`default_nettype none
module gal_latch_asserts #(
  parameter NF = 32
) (
  // clock, reset and bus answer
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // faults and alarm outputs
  input wire logic [NF-1:0] fault_raw,
  input wire logic          alarm_q,
  input wire logic          trouble_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("setup not answered");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("answer outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("refusal malformed");
  property p_rst; $rose(presetn) |-> !alarm_q && !trouble_q; endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_tset; fault_raw != '0 |=> ##1 trouble_q; endproperty
  a_tset: assert property (p_tset) else $error("fault not flagged");
  property p_tfall; $fell(trouble_q) |-> $past(fault_raw, 2) == '0; endproperty
  a_tfall: assert property (p_tfall) else $error("trouble left early");
  property p_stay; trouble_q && $past(fault_raw) != '0 |=> trouble_q; endproperty
  a_stay: assert property (p_stay) else $error("trouble dropped");
endmodule
`default_nettype wire

// *** tb/gal_latch_tb.sv ***
// self-checking bench for the gas alarm latch
`default_nettype none
module gal_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, fault_raw = 32'h0, prdata, r;
  logic        pready, pslverr, e, alarm_q, trouble_q;
  logic [15:0] reading = 16'h0;
  logic [2:0]  clr = 3'h0;
  logic [7:0]  ctl [6] = '{8'h09, 8'h01, 8'h08, 8'h09, 8'h11, 8'h01};
  logic [5:0]  hi = 6'b110000, ex = 6'b001011;
  int          bad_count = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  gal_latch #(.TICK_CYCLES(10)) gal_latch_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reading(reading), .fault_raw(fault_raw),
    .local_clear(clr[0]), .serial_clear(clr[1]), .remote_reset_pin(clr[2]),
    .alarm_q(alarm_q), .trouble_q(trouble_q));
  task automatic summarize();
    $display("checked %0d wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin bad_count++; summarize(); end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wa(logic v, int lo, int lim);
    int n;
    n = 0;
    while (alarm_q !== v && n < lim) begin @(posedge pclk); n++; end
    chk("alarm", {31'h0, v}, {31'h0, alarm_q});
    chk("delay", 32'h1, {31'h0, n >= lo});
    if (alarm_q !== v) summarize();
  endtask
  // two cycles so the remote pin synchroniser sees it
  task automatic pulse(int j);
    clr <= 3'(1 << j);
    repeat (2) @(posedge pclk);
    clr <= 3'h0;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(1, 12'h004, 32'h64);
    apb(0, 12'h008, 32'h0);
    chk("clear level", 32'h64, r);
    apb(1, 12'h00C, 32'hF);
    apb(0, 12'h00C, 32'h0);
    chk("entry max", 32'hA, r);
    apb(1, 12'h010, 32'h2328);
    apb(0, 12'h010, 32'h0);
    chk("exit max", 32'h1C20, r);
    apb(0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("register test done");
    apb(1, 12'h00C, 32'h3);
    apb(1, 12'h010, 32'h2);
    apb(1, 12'h000, 32'h1);
    // two ticks on the trip side, then a dip must restart the count
    reading <= 16'hC8;
    repeat (20) @(posedge pclk);
    reading <= 16'h32;
    @(posedge pclk);
    reading <= 16'hC8;
    wa(1, 19, 60);
    reading <= 16'h32;
    wa(0, 9, 60);
    $display("auto test done");
    apb(1, 12'h000, 32'h5);
    for (int j = 0; j < 3; j++) begin
      reading <= 16'hC8;
      wa(1, 19, 60);
      pulse(j);
      chk("clear while high", 32'h1, {31'h0, alarm_q});
      reading <= 16'h32;
      repeat (40) @(posedge pclk);
      chk("manual hold", 32'h1, {31'h0, alarm_q});
      pulse(j);
      wa(0, 0, 10);
    end
    $display("manual test done");
    fault_raw <= 32'h1;
    repeat (3) @(posedge pclk);
    chk("trouble on", 32'h1, {31'h0, trouble_q});
    fault_raw <= 32'h0;
    repeat (3) @(posedge pclk);
    chk("trouble off", 32'h0, {31'h0, trouble_q});
    fault_raw <= 32'h10300;
    repeat (3) @(posedge pclk);
    fault_raw <= 32'h0;
    apb(0, 12'h01C, 32'h0);
    chk("code", 32'h10300, r);
    apb(1, 12'h024, 32'h10000);
    apb(0, 12'h01C, 32'h0);
    chk("code acked", 32'h300, r);
    apb(1, 12'h014, 32'h2);
    apb(0, 12'h020, 32'h0);
    chk("walk active", 32'h1, {31'h0, r[5]});
    $display("trouble test done");
    apb(1, 12'h00C, 32'h0);
    apb(1, 12'h010, 32'h0);
    for (int i = 0; i < 6; i++) begin
      reading <= hi[i] ? 16'hC8 : 16'h32;
      apb(1, 12'h000, {24'h0, ctl[i]});
      repeat (5) @(posedge pclk);
      chk("override", {31'h0, ex[i]}, {31'h0, alarm_q});
    end
    $display("override test done");
    summarize();
  end
endmodule
bind gal_latch gal_latch_asserts #(.NF(NF)) gal_latch_asserts_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fault_raw(fault_raw), .alarm_q(alarm_q), .trouble_q(trouble_q));
`default_nettype wire
